//--- include/gtp_pkg.sv
// constants and types for the gear tooth peak detector
package gtp_pkg;
  localparam int          SAMPLE_W    = 10;
  localparam int          HYST_W      = 4;
  localparam int          CLK_MHZ     = 125;
  localparam int          INIT_MS     = 50;
  localparam int          INIT_CYC    = INIT_MS * 1000 * CLK_MHZ;
  localparam int          SAMPLE_DIV  = 125;
  localparam logic [3:0]  HYST_RST    = 4'h8;
  localparam logic [9:0]  SAMPLE_RST  = 10'h000;

  typedef enum logic [1:0] {
    GTP_ST_INIT    = 2'b00,
    GTP_ST_FALLING = 2'b01,
    GTP_ST_RISING  = 2'b10
  } gtp_state_t;
endpackage : gtp_pkg

//--- include/gtp_smp_if.sv
// sample handoff between the sampler and the tracker
`timescale 1ns/10ps
interface gtp_smp_if;
  logic       valid;
  logic [9:0] data;
  modport src (output valid, output data);
  modport dst (input  valid, input  data);
endinterface : gtp_smp_if

//--- hdl/gtp_sampler.sv
// sample-rate divider and digital sample-and-hold
`timescale 1ns/10ps
module gtp_sampler
  import gtp_pkg::*;
#(
  parameter int DIV = SAMPLE_DIV
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_adc_valid,
  input  wire logic [SAMPLE_W-1:0] i_adc_data,
  gtp_smp_if.src                   smp
);
  typedef struct packed {
    logic [15:0]         cnt;
    logic                valid;
    logic [SAMPLE_W-1:0] held;
  } gtp_smp_st_t;

  gtp_smp_st_t st_r;
  gtp_smp_st_t st_nxt;

  initial begin
    if (DIV < 1 || DIV > 65535) $error("DIV out of range");
  end

  // converter words are captured only on the divider tick, holding the rest
  always_comb begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    if (st_r.cnt == 16'(DIV - 1)) begin
      st_nxt.cnt = 16'h0000;
      if (i_adc_valid) begin
        st_nxt.held  = i_adc_data;
        st_nxt.valid = 1'b1;
      end
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '{cnt: 16'h0000, valid: 1'b0, held: SAMPLE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign smp.valid = st_r.valid;
  assign smp.data  = st_r.held;

  AST_HOLD_STABLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !st_r.valid |-> $stable(st_r.held))
    else $error("held sample changed without a strobe");
endmodule : gtp_sampler

//--- hdl/gtp_detector.sv
// top: peak and valley tracker driving an open-drain output
`timescale 1ns/10ps
module gtp_detector
  import gtp_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int DIV         = SAMPLE_DIV
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_adc_valid,
  input  wire logic [SAMPLE_W-1:0] i_adc_data,
  input  wire logic [HYST_W-1:0]   i_hyst,
  output logic                     o_out_o,
  output logic                     o_out_oe,
  output logic                     o_ready
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    gtp_state_t          state;
    logic [SAMPLE_W-1:0] ext;
    logic [HYST_W-1:0]   hyst;
    logic [26:0]         init_cnt;
    logic                ready;
    logic                out_low;
  } gtp_st_t;

  gtp_st_t st_r;
  gtp_st_t st_nxt;

  gtp_smp_if smp ();

  initial begin
    if (INIT_CYCLES < 1 || INIT_CYCLES > 134217727)
      $error("INIT_CYCLES out of range");
  end

  gtp_sampler #(
    .DIV (DIV)
  ) u_sampler (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_adc_valid (i_adc_valid),
    .i_adc_data  (i_adc_data),
    .smp         (smp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // distances widened by one bit so underflow cannot wrap into a trip
  logic [SAMPLE_W:0] rise_d;
  logic [SAMPLE_W:0] fall_d;
  logic              rise_trip;
  logic              fall_trip;

  always_comb begin
    rise_d    = {1'b0, smp.data} - {1'b0, st_r.ext};
    fall_d    = {1'b0, st_r.ext} - {1'b0, smp.data};
    rise_trip = !rise_d[SAMPLE_W] &&
                (rise_d >= (SAMPLE_W+1)'(st_r.hyst));
    fall_trip = !fall_d[SAMPLE_W] &&
                (fall_d >= (SAMPLE_W+1)'(st_r.hyst));
  end

  always_comb begin
    st_nxt = st_r;
    if (!st_r.ready) begin
      // output is not trusted until the settle time passes
      if (st_r.init_cnt == 27'(INIT_CYCLES - 1)) begin
        st_nxt.ready = 1'b1;
      end else begin
        st_nxt.init_cnt = st_r.init_cnt + 27'h000_0001;
      end
    end
    if (smp.valid) begin
      case (st_r.state)
        GTP_ST_INIT: begin
          // output high means the field last fell, so look for a valley
          st_nxt.ext   = smp.data;
          st_nxt.state = GTP_ST_FALLING;
        end
        GTP_ST_FALLING: begin
          if (smp.data < st_r.ext) begin
            st_nxt.ext = smp.data;
          end else if (rise_trip) begin
            st_nxt.out_low = 1'b1;
            st_nxt.ext     = smp.data;
            st_nxt.state   = GTP_ST_RISING;
          end
        end
        GTP_ST_RISING: begin
          if (smp.data > st_r.ext) begin
            st_nxt.ext = smp.data;
          end else if (fall_trip) begin
            st_nxt.out_low = 1'b0;
            st_nxt.ext     = smp.data;
            st_nxt.state   = GTP_ST_FALLING;
          end
        end
        default: begin
          st_nxt.state = GTP_ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // reset stands for a fast power-up, so the output starts released
      st_r.state    <= GTP_ST_INIT;
      st_r.ext      <= SAMPLE_RST;
      st_r.hyst     <= HYST_RST;
      st_r.init_cnt <= 27'h000_0000;
      st_r.ready    <= 1'b0;
      st_r.out_low  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      // hysteresis code is re-sampled from i_hyst on every clock after release
      st_r.hyst <= i_hyst;
    end
  end

  // open drain: only ever pulls low, the external pull-up gives high
  assign o_out_o  = 1'b0;
  assign o_out_oe = st_r.out_low;
  assign o_ready  = st_r.ready;

  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_HIGH: assert property (@(posedge i_clk)
    !i_rst_n |=> !o_out_oe)
    else $error("output not released after reset");

  AST_GO_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == GTP_ST_FALLING && smp.valid && smp.data >= st_r.ext &&
     rise_trip) |=> (o_out_oe && st_r.state == GTP_ST_RISING))
    else $error("output did not go low after valley reversal");

  AST_GO_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == GTP_ST_RISING && smp.valid && smp.data <= st_r.ext &&
     fall_trip) |=> (!o_out_oe && st_r.state == GTP_ST_FALLING))
    else $error("output did not go high after peak reversal");

  AST_NO_CHANGE_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !smp.valid |=> $stable(o_out_oe))
    else $error("output changed without a sample");

  AST_RELOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(o_out_oe) |-> st_r.ext == $past(smp.data))
    else $error("extreme not reloaded on transition");

  AST_TRACK_MIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == GTP_ST_FALLING && smp.valid && smp.data < st_r.ext)
    |=> st_r.ext == $past(smp.data))
    else $error("valley not tracked");

  AST_TRACK_MAX: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == GTP_ST_RISING && smp.valid && smp.data > st_r.ext)
    |=> st_r.ext == $past(smp.data))
    else $error("peak not tracked");

  AST_READY_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_ready |=> o_ready)
    else $error("ready dropped");

  AST_NOT_EARLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_ready) |-> $past(st_r.init_cnt) == 27'(INIT_CYCLES - 1))
    else $error("ready before init interval");
endmodule : gtp_detector

//--- sim/gtp_ctl_model.sv
// controller input model: pull-up resistor on the open-drain line
`timescale 1ns/10ps
module gtp_ctl_model (
  input  wire logic i_clk,
  input  wire logic i_out_o,
  input  wire logic i_out_oe,
  input  wire logic i_ready,
  output logic      o_line,
  output logic      o_level
);
  // pull-up wins whenever the device releases the pin
  assign o_line = i_out_oe ? i_out_o : 1'b1;
  // readings before ready are stale, so they are not taken
  always_ff @(posedge i_clk) begin
    if (i_ready) begin
      o_level <= o_line;
    end
  end
endmodule : gtp_ctl_model

//--- sim/gear_tooth_peak_detector_tb.sv
// self-checking bench for the gear tooth peak detector
`timescale 1ns/10ps
module gear_tooth_peak_detector_tb;
  import gtp_pkg::*;
  typedef struct { logic [9:0] d; logic q; } gtp_row_t;
  logic                i_clk;
  logic                i_rst_n;
  logic                i_adc_valid;
  logic [SAMPLE_W-1:0] i_adc_data;
  logic [HYST_W-1:0]   i_hyst;
  logic                o_out_o;
  logic                o_out_oe;
  logic                o_ready;
  logic                line;
  logic                level;
  int                  bad_count;
  int                  num_checks;
  // hysteresis 8: each trip sits exactly on the boundary
  gtp_row_t rows [12] = '{'{10'h1f0, 1'b1}, '{10'h1f7, 1'b1},
    '{10'h1f8, 1'b0}, '{10'h220, 1'b0}, '{10'h219, 1'b0},
    '{10'h218, 1'b1}, '{10'h21f, 1'b1}, '{10'h220, 1'b0},
    '{10'h3ff, 1'b0}, '{10'h3f7, 1'b1}, '{10'h000, 1'b1},
    '{10'h008, 1'b0}};
  ////////////////////////////////////////////////////////////////////////
  gtp_detector #(.INIT_CYCLES(20), .DIV(4)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_adc_valid(i_adc_valid),
    .i_adc_data(i_adc_data), .i_hyst(i_hyst), .o_out_o(o_out_o),
    .o_out_oe(o_out_oe), .o_ready(o_ready));
  gtp_ctl_model u_ctl (.i_clk(i_clk), .i_out_o(o_out_o),
    .i_out_oe(o_out_oe), .i_ready(o_ready), .o_line(line),
    .o_level(level));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic e, logic s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // word held 12 cycles: ticks take it, answer lands 2 edges later;
  // the caller looks on the falling edge, where the level has settled
  task automatic put(logic [9:0] d, logic v);
    @(posedge i_clk);
    i_adc_data  <= d;
    i_adc_valid <= v;
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
  endtask : put
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    chk("ready", 1'b1, o_ready);
    if (n >= 100) close_out();
  endtask : wait_ready
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    bad_count   = 0;
    num_checks  = 0;
    i_rst_n     = 1'b0;
    i_adc_valid = 1'b0;
    i_adc_data  = 10'h200;
    i_hyst      = 4'h8;
    repeat (8) @(posedge i_clk);
    chk("line in reset", 1'b1, line);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk("ready early", 1'b0, o_ready);
    wait_ready();
    $display("test power-up done");
    put(10'h200, 1'b1);
    foreach (rows[i]) begin
      put(rows[i].d, 1'b1);
      chk("row level", rows[i].q, level);
    end
    $display("test tracking rows done");
    // a tripping word with valid low must be ignored
    put(10'h000, 1'b0);
    chk("invalid word", 1'b0, level);
    $display("test invalid word done");
    // second power-up while the line is low
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("line re-reset", 1'b1, line);
    chk("ready re-reset", 1'b0, o_ready);
    i_rst_n <= 1'b1;
    wait_ready();
    $display("test second reset done");
    close_out();
  end
endmodule : gear_tooth_peak_detector_tb
